// File: src/rsc_pkg.sv
// rsc_pkg: shared constants and carriers for the ranging report block
// assumes one clock domain; all users write rsc_pkg::name
package rsc_pkg;
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned AMP_W = 16;
  localparam int unsigned OFS_W = 16;
  localparam int unsigned LIST_LEN_W = 16;  // two-octet entry count
  localparam int unsigned TRK_W = 32;
  localparam logic [7:0] MERIT_DEFERRED = 8'h00;  // deferral code on the merit field
  localparam logic [COUNT_W-1:0] START_RST = 32'h0000_0000;
  localparam logic [TRK_W-1:0] TRK_RST = 32'h0000_0000;
  localparam logic [TRK_W-1:0] ANALOG_SCALE = 32'h000F_4240;  // fixed interval for analog loop
  localparam logic [LIST_LEN_W-1:0] LIST_RST = 16'h0000;

  typedef enum logic [1:0] {
    RSC_IDLE = 2'b00,
    RSC_CAPT = 2'b01,
    RSC_HOLD = 2'b11,
    RSC_SEND = 2'b10
  } rsc_state_e;

  // one entry of the sounding list
  typedef struct packed {
    logic [OFS_W-1:0] time_ofs;   // positive means earlier than zero point
    logic [AMP_W-1:0] amplitude;  // linear, gain-normalised
  } rsc_pair_s;

  // timestamp report
  typedef struct packed {
    logic [COUNT_W-1:0] arrival_start_count;
    logic [7:0] ranging_merit_figure;
  } rsc_stamp_s;

  // crystal characterisation report
  typedef struct packed {
    logic [TRK_W-1:0] interval;
    logic ofs_sign;               // 1 = negative (remote faster)
    logic [TRK_W-1:0] ofs_mag;
  } rsc_xtal_s;
endpackage

// File: src/rsc_report.sv
// rsc_report: timestamp, sounding list and crystal offset report logic
// assumes receive front end delivers samples, gain steps and tracking events
// assumes the upper layer drains the list before the next packet starts
// assumes zero_mark is placed by the front end at the lock or launch point
// How it works
// - deferred start count left uncorrected
// - merit field shows deferral, no own figure
// - list entries pair time offset, amplitude
// - offset zero is amplitude at start
// - positive offset means earlier sample
// - amplitudes linear and relative only
// - gain changes rescaled to constant gain
// - list opens with two-octet entry count
// - edge sounding zero at tracking lock
// - loopback zero at pulse launch
// - digital loop locked whole packet; analog loop locked at packet end only
// - count tracked time units as interval
// - count inserted/removed units as offset
// - positive inserts slower, negative faster
// - offset is sign and magnitude
// - interval and offset share one unit
// - analog loop digitises error, fixed interval
`timescale 1ns/1ps
module rsc_report #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned GAIN_SH_W = 4,
  parameter bit ANALOG_LOOP = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // mode
  input wire logic defer_edge,
  input wire logic loopback_mode,
  // packet and tracking loop
  input wire logic pkt_start,
  input wire logic pkt_end,
  input wire logic trk_locked,
  input wire logic trk_unit,
  input wire logic trk_insert,
  input wire logic trk_remove,
  input wire logic [rsc_pkg::TRK_W-1:0] analog_err_mag,
  input wire logic analog_err_neg,
  // arrival timestamp
  input wire logic stamp_valid,
  input wire logic [rsc_pkg::COUNT_W-1:0] raw_start_count,
  input wire logic [rsc_pkg::COUNT_W-1:0] edge_correction,
  input wire logic [7:0] own_merit,
  // sounding samples
  input wire logic zero_mark,
  input wire logic samp_valid,
  input wire logic [rsc_pkg::AMP_W-1:0] samp_amp,
  input wire logic [GAIN_SH_W-1:0] gain_shift,
  // sounding request and answer stream
  input wire logic snd_req,
  output logic snd_valid,
  input wire logic snd_ready,
  output logic snd_is_count,
  output logic snd_last,
  output logic [rsc_pkg::LIST_LEN_W-1:0] snd_count,
  output rsc_pkg::rsc_pair_s sounding_sample_pair,
  // reports
  output rsc_pkg::rsc_stamp_s stamp_q,
  output logic stamp_strobe,
  output rsc_pkg::rsc_xtal_s xtal_q,
  output logic xtal_strobe
);
  // AW is the array address width; a DEPTH below two is refused below
  localparam int unsigned AW = $clog2(DEPTH);

  // elaboration checks: the count is two octets, the shifter at most four bits wide
  if (DEPTH < 2 || DEPTH > 65535) begin : g_bad_depth
    $error("DEPTH out of range");
  end
  if (GAIN_SH_W > 4) begin : g_bad_gain
    $error("GAIN_SH_W too wide");
  end

  // sounding_sample_list storage: amplitude and capture index
  // arrays without reset: only entries below the write pointer are read
  logic [rsc_pkg::AMP_W-1:0] amp_mem [DEPTH];
  logic [rsc_pkg::OFS_W-1:0] ofs_mem [DEPTH];

  rsc_pkg::rsc_state_e st_q, st_d;
  logic [rsc_pkg::LIST_LEN_W-1:0] wr_q, rd_q;
  logic [rsc_pkg::OFS_W-1:0] zero_idx_q;
  logic zero_seen_q;
  logic cnt_sent_q;
  logic [rsc_pkg::TRK_W-1:0] intv_q, ins_q, rem_q;
  logic locked_q;

  // linear samples; rescale to top gain
  // a shift past the top bit clips at full scale instead of wrapping; a
  // wrapped strong sample would read as weak and fake an earlier edge
  wire [rsc_pkg::AMP_W+14:0] wide_amp = {15'h0000, samp_amp} << gain_shift;
  wire amp_clip = |wide_amp[rsc_pkg::AMP_W+14:rsc_pkg::AMP_W];
  wire [rsc_pkg::AMP_W-1:0] norm_amp = amp_clip ? {rsc_pkg::AMP_W{1'b1}}
                                                : wide_amp[rsc_pkg::AMP_W-1:0];
  // capture stops at DEPTH entries; later samples are dropped, not wrapped
  wire cap_en = (st_q == rsc_pkg::RSC_CAPT) && samp_valid && (wr_q < 16'(DEPTH));
  wire [rsc_pkg::OFS_W-1:0] wr_idx = wr_q;
  wire [AW-1:0] wr_addr = wr_q[AW-1:0];
  wire [AW-1:0] rd_addr = rd_q[AW-1:0];

  // edge sounding zero at tracking hold point
  // loopback zero at launch marker
  // loopback_mode only says which marker the front end sends; both share
  // one path, so the mode itself needs no logic here
  wire zero_hit = zero_mark && !zero_seen_q;

  // capture stores raw index; offsets formed at read against zero point
  // the zero marker may come after earlier samples, so offsets can only be
  // formed once the whole capture is known
  always_ff @(posedge clk) begin
    if (cap_en) begin
      amp_mem[wr_addr] <= norm_amp;
      ofs_mem[wr_addr] <= wr_idx;
    end
  end

  // zero offset at start point; earlier is positive
  wire [rsc_pkg::OFS_W-1:0] stored_idx = ofs_mem[rd_addr];
  wire [rsc_pkg::OFS_W-1:0] signed_ofs = zero_idx_q - stored_idx;

  // state machine: capture on packet, hold, send on request
  // hold capture until read or new packet
  // all four codes are legal, so the case needs no default
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      // nothing captured since reset
      rsc_pkg::RSC_IDLE: begin
        if (pkt_start) begin
          st_d = rsc_pkg::RSC_CAPT;
        end
      end
      // samples flow into the arrays until the packet ends
      rsc_pkg::RSC_CAPT: begin
        if (pkt_end) begin
          st_d = rsc_pkg::RSC_HOLD;
        end
      end
      // a new packet wins over a request in the same cycle: the old list is
      // about to be overwritten and must not be shown half replaced
      rsc_pkg::RSC_HOLD: begin
        if (pkt_start) begin
          st_d = rsc_pkg::RSC_CAPT;
        end else if (snd_req) begin
          st_d = rsc_pkg::RSC_SEND;
        end
      end
      // a packet arriving mid read is lost rather than corrupting the list
      rsc_pkg::RSC_SEND: begin
        if (snd_valid && snd_ready && snd_last) begin
          st_d = rsc_pkg::RSC_HOLD;
        end
      end
    endcase
  end

  // answer stream: count word first, then pairs
  // valid rises the cycle after a taken request and stays up until the last
  // beat; the upper layer may stall any beat for as long as it likes
  wire sending = (st_q == rsc_pkg::RSC_SEND);
  assign snd_is_count = sending && !cnt_sent_q;
  assign snd_valid = sending;
  // last beat: the count itself for an empty list, else the final pair
  wire list_empty = (wr_q == rsc_pkg::LIST_RST);
  wire last_pair = (rd_q + 16'h0001 >= wr_q);
  assign snd_last = sending && (cnt_sent_q ? last_pair : list_empty);
  // the write pointer doubles as the entry count
  assign snd_count = wr_q;
  // each entry a time offset with amplitude
  // pairs come straight from the arrays, so a stall holds them for free
  assign sounding_sample_pair = '{time_ofs: signed_ofs, amplitude: amp_mem[rd_addr]};
  wire beat = snd_valid && snd_ready;

  // list decode: a new packet may not disturb a list that is being read out
  wire new_list = pkt_start && (st_q != rsc_pkg::RSC_SEND);
  wire zero_take = zero_hit && (st_q == rsc_pkg::RSC_CAPT);
  wire read_start = (st_q == rsc_pkg::RSC_HOLD) && snd_req;
  wire count_beat = beat && !cnt_sent_q;
  wire pair_beat = beat && cnt_sent_q;

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= rsc_pkg::RSC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // write pointer: restarts with each packet not arriving mid read, counts stored samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= rsc_pkg::LIST_RST;
    end else if (new_list) begin
      wr_q <= rsc_pkg::LIST_RST;
    end else if (cap_en) begin
      wr_q <= wr_q + 16'h0001;
    end
  end

  // zero point: first marker of a packet only; a marker in the same cycle
  // as a new packet lands on its first entry only if capture was already running, else it is dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_idx_q <= rsc_pkg::LIST_RST;
      zero_seen_q <= 1'b0;
    end else if (new_list) begin
      zero_idx_q <= rsc_pkg::LIST_RST;
      zero_seen_q <= zero_take;
    end else if (zero_take) begin
      zero_idx_q <= wr_q;
      zero_seen_q <= 1'b1;
    end
  end

  // read side: restarts on every request taken in hold, so one list can be read again
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= rsc_pkg::LIST_RST;
      cnt_sent_q <= 1'b0;
    end else if (read_start) begin
      rd_q <= rsc_pkg::LIST_RST;
      cnt_sent_q <= 1'b0;
    end else if (count_beat) begin
      cnt_sent_q <= 1'b1;
    end else if (pair_beat) begin
      rd_q <= rd_q + 16'h0001;
    end
  end

  // timestamp report
  // no correction when deferred; deferral code
  // the deferred path never looks at the correction input, so a stale
  // correction cannot leak into a deferred report
  // stamp_strobe follows every stamp_valid, deferred or not
  wire [rsc_pkg::COUNT_W-1:0] start_d = defer_edge ? raw_start_count
                                                  : raw_start_count - edge_correction;
  wire [7:0] merit_d = defer_edge ? rsc_pkg::MERIT_DEFERRED : own_merit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stamp_q <= '{arrival_start_count: rsc_pkg::START_RST, ranging_merit_figure: 8'h00};
      stamp_strobe <= 1'b0;
    end else begin
      stamp_strobe <= stamp_valid;
      if (stamp_valid) begin
        stamp_q <= '{arrival_start_count: start_d, ranging_merit_figure: merit_d};
      end
    end
  end

  // tracking events as one vector: unit, insert, remove
  // interval counts tracked units
  // all counts in the loop's unit
  // counters run free between packets; only the packet window is reported
  wire [2:0] trk_evt = {trk_remove, trk_insert, trk_unit};

  // one counter per event kind; a new packet restarts all three
  // separate counters, since a unit and a slip may fall in one cycle
  for (genvar k = 0; k < 3; k++) begin : g_trk_cnt
    logic [rsc_pkg::TRK_W-1:0] cnt_q;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q <= rsc_pkg::TRK_RST;
      end else if (pkt_start) begin
        cnt_q <= rsc_pkg::TRK_RST;
      end else if (trk_evt[k]) begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end
  assign intv_q = g_trk_cnt[0].cnt_q;
  assign ins_q = g_trk_cnt[1].cnt_q;
  assign rem_q = g_trk_cnt[2].cnt_q;

  // valid only if locked whole packet
  // lock loss latches until the next packet; a new packet re-arms it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      locked_q <= 1'b0;
    end else if (pkt_start) begin
      locked_q <= 1'b1;
    end else if (!trk_locked) begin
      locked_q <= 1'b0;
    end
  end

  // net insertions positive; sign and magnitude
  wire net_neg = rem_q > ins_q;
  wire [rsc_pkg::TRK_W-1:0] net_mag = net_neg ? rem_q - ins_q : ins_q - rem_q;
  // analog loop uses digitised error and fixed scale
  // the loop variant is fixed at build time, so only one report path exists
  logic [rsc_pkg::TRK_W-1:0] rep_intv, rep_mag;
  logic rep_neg, xtal_ok;
  if (ANALOG_LOOP) begin : g_analog
    // lock judged at packet end only; an analog loop keeps no event count
    assign rep_intv = rsc_pkg::ANALOG_SCALE;
    assign rep_mag = analog_err_mag;
    assign rep_neg = analog_err_neg;
    assign xtal_ok = trk_locked;
  end else begin : g_digital
    // a single slip of lock spoils the count, so the whole packet must hold
    assign rep_intv = intv_q;
    assign rep_mag = net_mag;
    assign rep_neg = net_neg;
    assign xtal_ok = locked_q && trk_locked;
  end

  // report latched at packet end; a zero magnitude never carries a minus
  // no strobe for an untrustworthy report, and the previous one stays put
  wire xtal_take = pkt_end && xtal_ok;
  wire xtal_neg = rep_neg && (rep_mag != '0);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xtal_q <= '{interval: rsc_pkg::TRK_RST, ofs_sign: 1'b0, ofs_mag: rsc_pkg::TRK_RST};
      xtal_strobe <= 1'b0;
    end else begin
      xtal_strobe <= xtal_take;
      if (xtal_take) begin
        xtal_q <= '{interval: rep_intv, ofs_sign: xtal_neg, ofs_mag: rep_mag};
      end
    end
  end
endmodule

// File: test/rsc_report_sva.sv
// rsc_report_chk: stream handshake and report checks on rsc_report ports
// assumes one clk domain and arst_n asynchronous, active low
`timescale 1ns/1ps
module rsc_report_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // causes
  input wire logic defer_edge,
  input wire logic pkt_end,
  input wire logic stamp_valid,
  input wire logic [rsc_pkg::COUNT_W-1:0] raw_start_count,
  input wire logic [rsc_pkg::COUNT_W-1:0] edge_correction,
  input wire logic [7:0] own_merit,
  // stream
  input wire logic snd_valid,
  input wire logic snd_ready,
  input wire logic snd_is_count,
  input wire logic snd_last,
  input wire logic [rsc_pkg::LIST_LEN_W-1:0] snd_count,
  input wire rsc_pkg::rsc_pair_s sounding_sample_pair,
  // reports
  input wire rsc_pkg::rsc_stamp_s stamp_q,
  input wire logic stamp_strobe,
  input wire rsc_pkg::rsc_xtal_s xtal_q,
  input wire logic xtal_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a beat moves one unit; a wait must keep it in place
  sequence s_beat; snd_valid && snd_ready; endsequence
  sequence s_wait; snd_valid && !snd_ready; endsequence
  property p_raw;
    stamp_valid && defer_edge |=> stamp_q.arrival_start_count == $past(raw_start_count);
  endproperty
  property p_merit;
    stamp_valid && defer_edge |=> stamp_strobe
      && stamp_q.ranging_merit_figure == rsc_pkg::MERIT_DEFERRED;
  endproperty
  property p_corr;
    stamp_valid && !defer_edge |=> stamp_q.arrival_start_count
      == $past(raw_start_count) - $past(edge_correction);
  endproperty
  property p_own;
    stamp_valid && !defer_edge |=> stamp_q.ranging_merit_figure == $past(own_merit);
  endproperty
  property p_hold;
    s_wait |=> snd_valid && $stable(sounding_sample_pair) && $stable(snd_is_count);
  endproperty
  property p_head; $rose(snd_valid) |-> snd_is_count; endproperty
  property p_empty; s_beat ##0 snd_is_count |-> snd_last == (snd_count == 16'h0000); endproperty
  property p_end; s_beat ##0 snd_last |=> !snd_valid; endproperty
  property p_xtal; xtal_strobe |-> $past(pkt_end); endproperty
  property p_sign; xtal_strobe |-> !(xtal_q.ofs_sign && xtal_q.ofs_mag == '0); endproperty
  a_raw: assert property (p_raw) else $error("start count corrected");
  a_merit: assert property (p_merit) else $error("merit not deferral code");
  a_corr: assert property (p_corr) else $error("start count not corrected");
  a_own: assert property (p_own) else $error("own merit figure lost");
  a_hold: assert property (p_hold) else $error("stalled beat changed");
  a_head: assert property (p_head) else $error("list not led by count");
  a_empty: assert property (p_empty) else $error("last flag wrong on count");
  a_end: assert property (p_end) else $error("valid after last beat");
  a_xtal: assert property (p_xtal) else $error("crystal report untimely");
  a_sign: assert property (p_sign) else $error("negative zero offset");
endmodule
bind rsc_report rsc_report_chk u_chk (.clk, .arst_n, .defer_edge, .pkt_end, .stamp_valid,
  .raw_start_count, .edge_correction, .own_merit, .snd_valid, .snd_ready, .snd_is_count,
  .snd_last, .snd_count,
  .sounding_sample_pair, .stamp_q, .stamp_strobe, .xtal_q, .xtal_strobe);

// File: test/rsc_upper.sv
// rsc_upper: upper layer model that requests and drains the sounding list
// assumes the rsc_report stream handshake; slow mode stalls every other cycle
`timescale 1ns/1ps
module rsc_upper (
  // clock
  input wire logic clk,
  // stream
  output logic snd_req,
  output logic snd_ready,
  input wire logic snd_valid,
  input wire logic snd_is_count,
  input wire logic snd_last,
  input wire logic [rsc_pkg::LIST_LEN_W-1:0] snd_count,
  input wire rsc_pkg::rsc_pair_s sounding_sample_pair
);
  rsc_pkg::rsc_pair_s got[$];
  logic [15:0] cnt;
  // idle until asked
  initial begin
    snd_req = 1'b0;
    snd_ready = 1'b0;
  end
  task automatic fetch(input bit slow);
    int n;
    got.delete();
    cnt = 16'hFFFF;
    snd_req = 1'b1;
    @(posedge clk);
    #1 snd_req = 1'b0;
    for (n = 0; n < 99; n++) begin
      snd_ready = !slow || n[0];
      @(posedge clk);
      if (snd_valid && snd_ready && snd_is_count) cnt = snd_count;
      else if (snd_valid && snd_ready) got.push_back(sounding_sample_pair);
      if (snd_valid && snd_ready && snd_last) break;
      #1;
    end
    #1 snd_ready = 1'b0;
  endtask
endmodule

// File: test/tb.sv
// tb: self-checking bench for rsc_report with the upper layer model
// assumes 20 MHz clk, inputs driven 1 ns after the rising edge
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, arst_n = 1'b0, defer_edge = 1'b1, loopback_mode = 1'b0;
  logic pkt_start = 1'b0, pkt_end = 1'b0, trk_locked = 1'b0, trk_unit = 1'b0;
  logic trk_insert = 1'b0, trk_remove = 1'b0, stamp_valid = 1'b0;
  logic zero_mark = 1'b0, samp_valid = 1'b0;
  logic [15:0] samp_amp = 16'h0000;
  logic [3:0] gain_shift = 4'h0;
  logic [31:0] raw_start_count = 32'h0000_0000;
  logic [31:0] edge_correction = 32'h0000_0010;
  logic [7:0] own_merit = 8'h55;
  logic snd_req, snd_ready, snd_valid, snd_is_count, snd_last, stamp_strobe, xtal_strobe;
  logic [15:0] snd_count;
  rsc_pkg::rsc_pair_s sounding_sample_pair;
  rsc_pkg::rsc_stamp_s stamp_q;
  rsc_pkg::rsc_xtal_s xtal_q;
  int errors = 0, tests_run = 0, cyc = 0;
  // clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  rsc_report dut (.clk, .arst_n, .defer_edge, .loopback_mode, .pkt_start, .pkt_end,
    .trk_locked, .trk_unit, .trk_insert, .trk_remove, .analog_err_mag(32'h0000_0000),
    .analog_err_neg(1'b0), .stamp_valid, .raw_start_count, .edge_correction,
    .own_merit, .zero_mark, .samp_valid, .samp_amp, .gain_shift, .snd_req,
    .snd_valid, .snd_ready, .snd_is_count, .snd_last, .snd_count, .sounding_sample_pair,
    .stamp_q, .stamp_strobe, .xtal_q, .xtal_strobe);
  rsc_upper up (.clk, .snd_req, .snd_ready, .snd_valid, .snd_is_count, .snd_last,
    .snd_count, .sounding_sample_pair);
  task automatic chk(input logic [64:0] g, input logic [64:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // six cycles of tracking; zero point after two samples, none sampled there
  task automatic run_pkt(input bit smp, input bit up_dir);
    int i, j;
    j = 0;
    pkt_start = 1'b1;
    tick(1);
    pkt_start = 1'b0;
    for (i = 0; i < 6; i++) begin
      zero_mark = (i == 2);
      samp_valid = smp && (i != 2);
      samp_amp = 16'(j * 16 + 3);
      gain_shift = 4'(j % 4);
      trk_unit = 1'b1;
      trk_insert = up_dir && i < 3;
      trk_remove = !up_dir && i < 4;
      tick(1);
      j += int'(samp_valid);
    end
    {zero_mark, samp_valid, trk_unit, trk_insert, trk_remove} = 5'h00;
    pkt_end = 1'b1;
    tick(1);
    chk(65'(xtal_strobe), 65'(1)); // report issued
    pkt_end = 1'b0;
    tick(2);
  endtask
  // list: count first, then offsets from the zero point and rescaled amplitudes
  task automatic chk_list(input int n);
    int j;
    chk(65'(up.cnt), 65'(n)); // two-octet count
    chk(65'(up.got.size()), 65'(n)); // pair count
    for (j = 0; j < up.got.size(); j++)
      chk(65'(up.got[j]), 65'({16'(2 - j), 16'((j * 16 + 3) << (j % 4))})); // pairs
  endtask
  task automatic t_stamp();
    raw_start_count = 32'h1234_5678;
    stamp_valid = 1'b1;
    tick(1);
    chk(65'(stamp_strobe), 65'(1)); // report strobe
    stamp_valid = 1'b0;
    tick(1);
    chk(65'(stamp_q), 65'({32'h1234_5678, rsc_pkg::MERIT_DEFERRED})); // stamp
    defer_edge = 1'b0;
    stamp_valid = 1'b1;
    tick(1);
    stamp_valid = 1'b0;
    defer_edge = 1'b1;
    chk(65'(stamp_q), 65'({32'h1234_5668, 8'h55})); // own correction
    $display("stamp test done");
  endtask
  task automatic t_sound();
    run_pkt(1'b1, 1'b1);
    chk(65'(xtal_q), {32'h0000_0006, 1'b0, 32'h0000_0003}); // slower
    up.fetch(1'b1);
    chk_list(5); // slow read
    up.fetch(1'b0);
    chk_list(5); // read again
    $display("sounding test done");
  endtask
  task automatic t_empty();
    run_pkt(1'b0, 1'b0);
    chk(65'(xtal_q), {32'h0000_0006, 1'b1, 32'h0000_0004}); // faster
    up.fetch(1'b0);
    chk_list(0); // empty list
    $display("empty test done");
  endtask
  // lock lost for one cycle inside a packet: no crystal report
  task automatic t_unlock();
    pkt_start = 1'b1;
    tick(1);
    pkt_start = 1'b0;
    trk_locked = 1'b0;
    tick(1);
    trk_locked = 1'b1;
    pkt_end = 1'b1;
    tick(1);
    pkt_end = 1'b0;
    chk(65'(xtal_strobe), 65'(0)); // lock lost
    tick(1);
    $display("unlock test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // reset for 20 cycles, then the scenarios
  initial begin
    tick(20);
    arst_n = 1'b1;
    trk_locked = 1'b1;
    tick(1);
    t_stamp();
    t_sound();
    t_empty();
    t_unlock();
    print_verdict();
  end
endmodule
